/* File: include/cmp_ctl_pkg.sv */
// Constants, field layouts and reset values for the comparator control logic
// Overview of operation
// - Output edges set rise or fall flags
// - Edge flags stay set until software clears
// - Status bit shows live comparator output
// - Enable bit powers each comparator independently
// - Disabled comparator: pin low, interrupts suspended
// - Rise and fall interrupts each separately enabled
// - Fall interrupt only when its enable set
// - Two-bit response mode, 0 fastest, 3 lowest power
// - Low control bits select negative hysteresis
// - Control bits 3:2 select positive hysteresis
// - Only first comparator may cause reset
// - Second comparator identical, own registers
// - Second mode register resets to 0x02
package cmp_ctl_pkg;

  // Special-function register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register addresses in the special-function space
  localparam logic [7:0] CTRL0_ADDR = 8'h88;
  localparam logic [7:0] MODE0_ADDR = 8'h89;
  localparam logic [7:0] CTRL1_ADDR = 8'h8c;
  localparam logic [7:0] MODE1_ADDR = 8'h8d;

  // Control register field positions
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_OUT_BIT = 6;
  localparam int CTRL_RIF_BIT = 5;
  localparam int CTRL_FIF_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;
  localparam int HYST_W       = 2;

  // Mode register field positions
  localparam int MODE_RIE_BIT = 5;
  localparam int MODE_FIE_BIT = 4;
  localparam int MODE_MD_LSB  = 0;
  localparam int MD_W         = 2;

  // Reset values and masks of implemented bits
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'h02;
  localparam logic [7:0] MODE_MASK = 8'h33;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Response time selection
  typedef logic [MD_W-1:0] resp_mode_t;
  localparam resp_mode_t RESP_FASTEST      = 2'h0;
  localparam resp_mode_t RESP_LOWEST_POWER = 2'h3;

  // Hysteresis selection, zero means disabled
  typedef logic [HYST_W-1:0] hyst_sel_t;
  localparam hyst_sel_t HYST_OFF = 2'h0;

endpackage

/* File: design/cmp_channel.sv */
// One comparator channel: synchroniser, edge flags, control and mode fields
`timescale 1ns/10ps
module cmp_channel (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  input  wire logic                    i_cmp_raw,
  input  wire logic                    i_ctrl_wr,
  input  wire logic                    i_mode_wr,
  input  wire logic [7:0]              i_wdata,
  output logic                         o_enable,
  output logic                         o_state,
  output logic                         o_rise_flag,
  output logic                         o_fall_flag,
  output cmp_ctl_pkg::hyst_sel_t       o_pos_hyst,
  output cmp_ctl_pkg::hyst_sel_t       o_neg_hyst,
  output logic                         o_rise_ie,
  output logic                         o_fall_ie,
  output cmp_ctl_pkg::resp_mode_t      o_resp_mode,
  output logic                         o_pin,
  output logic                         o_rise_irq,
  output logic                         o_fall_irq
);

  logic sync1_r;   // First synchroniser stage, read only by sync2_r
  logic sync2_r;   // Settled comparator level
  logic prev_r;    // Level one cycle earlier, for edge detection
  logic rise_ev;   // Rising transition seen this cycle
  logic fall_ev;   // Falling transition seen this cycle

  // Two-flop synchroniser for the analog output
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (i_ce) begin
      sync1_r <= i_cmp_raw;
      sync2_r <= sync1_r;
    end
  end

  // Previous level tracks the live one while disabled, so enabling makes an edge only if the level changed at the edge that set the enable bit
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_r <= 1'b0;
    end else if (i_ce) begin
      prev_r <= sync2_r;
    end
  end

  // Edges count only while enabled and once per transition
  assign rise_ev = o_enable & sync2_r & ~prev_r;
  assign fall_ev = o_enable & ~sync2_r & prev_r;

  // Enable and hysteresis fields of the control register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_enable   <= cmp_ctl_pkg::CTRL_RST[cmp_ctl_pkg::CTRL_EN_BIT];
      o_pos_hyst <= cmp_ctl_pkg::HYST_OFF;
      o_neg_hyst <= cmp_ctl_pkg::HYST_OFF;
    end else if (i_ce && i_ctrl_wr) begin
      o_enable   <= i_wdata[cmp_ctl_pkg::CTRL_EN_BIT];
      o_pos_hyst <= i_wdata[cmp_ctl_pkg::CTRL_HYP_LSB +: cmp_ctl_pkg::HYST_W];
      o_neg_hyst <= i_wdata[cmp_ctl_pkg::CTRL_HYN_LSB +: cmp_ctl_pkg::HYST_W];
    end
  end

  // Sticky edge flags; a hardware set wins over a software clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rise_flag <= cmp_ctl_pkg::CTRL_RST[cmp_ctl_pkg::CTRL_RIF_BIT];
      o_fall_flag <= cmp_ctl_pkg::CTRL_RST[cmp_ctl_pkg::CTRL_FIF_BIT];
    end else if (i_ce) begin
      if (rise_ev) begin
        o_rise_flag <= 1'b1;
      end else if (i_ctrl_wr) begin
        o_rise_flag <= i_wdata[cmp_ctl_pkg::CTRL_RIF_BIT];
      end
      if (fall_ev) begin
        o_fall_flag <= 1'b1;
      end else if (i_ctrl_wr) begin
        o_fall_flag <= i_wdata[cmp_ctl_pkg::CTRL_FIF_BIT];
      end
    end
  end

  // Mode register: interrupt enables and response time, unused bits dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rise_ie   <= cmp_ctl_pkg::MODE_RST[cmp_ctl_pkg::MODE_RIE_BIT];
      o_fall_ie   <= cmp_ctl_pkg::MODE_RST[cmp_ctl_pkg::MODE_FIE_BIT];
      o_resp_mode <= cmp_ctl_pkg::MODE_RST[cmp_ctl_pkg::MODE_MD_LSB +: cmp_ctl_pkg::MD_W];
    end else if (i_ce && i_mode_wr) begin
      o_rise_ie   <= i_wdata[cmp_ctl_pkg::MODE_RIE_BIT];
      o_fall_ie   <= i_wdata[cmp_ctl_pkg::MODE_FIE_BIT];
      o_resp_mode <= i_wdata[cmp_ctl_pkg::MODE_MD_LSB +: cmp_ctl_pkg::MD_W];
    end
  end

  // Routed pin output, held low while the comparator is off
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pin <= 1'b0;
    end else if (i_ce) begin
      o_pin <= o_enable & sync2_r;
    end
  end

  // Live status reads low while disabled, matching the forced pin level
  assign o_state = o_enable & sync2_r;

  // Interrupt requests gated by enable bit and comparator power
  assign o_rise_irq = o_rise_flag & o_rise_ie & o_enable;
  assign o_fall_irq = o_fall_flag & o_fall_ie & o_enable;

endmodule

/* File: design/analog_comparator_control.sv */
// Top of the two-comparator control block with its special-function registers
`timescale 1ns/10ps
module analog_comparator_control (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  input  wire logic [7:0]              i_sfr_addr,
  input  wire logic [7:0]              i_sfr_wdata,
  input  wire logic                    i_sfr_wr,
  input  wire logic                    i_sfr_rd,
  output logic      [7:0]              o_sfr_rdata,
  output logic                         o_sfr_hit,
  input  wire logic                    i_cmp0_raw,
  input  wire logic                    i_cmp1_raw,
  input  wire logic                    i_cmp0_rst_src_en,
  output logic                         o_cmp0_enable,
  output cmp_ctl_pkg::resp_mode_t      o_cmp0_resp_mode,
  output cmp_ctl_pkg::hyst_sel_t       o_cmp0_pos_hyst,
  output cmp_ctl_pkg::hyst_sel_t       o_cmp0_neg_hyst,
  output logic                         o_cmp0_pin,
  output logic                         o_cmp0_rise_irq,
  output logic                         o_cmp0_fall_irq,
  output logic                         o_cmp0_reset_req,
  output logic                         o_cmp1_enable,
  output cmp_ctl_pkg::resp_mode_t      o_cmp1_resp_mode,
  output cmp_ctl_pkg::hyst_sel_t       o_cmp1_pos_hyst,
  output cmp_ctl_pkg::hyst_sel_t       o_cmp1_neg_hyst,
  output logic                         o_cmp1_pin,
  output logic                         o_cmp1_rise_irq,
  output logic                         o_cmp1_fall_irq
);

  // Address decode strobes
  logic ctrl0_sel;   // Control register of comparator 0 addressed
  logic mode0_sel;   // Mode register of comparator 0 addressed
  logic ctrl1_sel;   // Control register of comparator 1 addressed
  logic mode1_sel;   // Mode register of comparator 1 addressed
  logic ctrl0_wr;    // Write to control 0
  logic mode0_wr;    // Write to mode 0
  logic ctrl1_wr;    // Write to control 1
  logic mode1_wr;    // Write to mode 1
  logic mode_rd;     // Read of either mode register

  // Per-channel state seen by the read mux
  logic c0_state;    // Comparator 0 live level
  logic c0_rise;     // Comparator 0 rising flag
  logic c0_fall;     // Comparator 0 falling flag
  logic c0_rie;      // Comparator 0 rising interrupt enable
  logic c0_fie;      // Comparator 0 falling interrupt enable
  logic c1_state;    // Comparator 1 live level
  logic c1_rise;     // Comparator 1 rising flag
  logic c1_fall;     // Comparator 1 falling flag
  logic c1_rie;      // Comparator 1 rising interrupt enable
  logic c1_fie;      // Comparator 1 falling interrupt enable

  logic [7:0] ctrl0_byte;  // Assembled control 0 read value
  logic [7:0] mode0_byte;  // Assembled mode 0 read value
  logic [7:0] ctrl1_byte;  // Assembled control 1 read value
  logic [7:0] mode1_byte;  // Assembled mode 1 read value
  logic [7:0] rdata_nxt;   // Read data for the addressed register
  logic       rst_cond;    // Comparator 0 asks for a system reset

  // Decode of the four registers
  assign ctrl0_sel = (i_sfr_addr == cmp_ctl_pkg::CTRL0_ADDR);
  assign mode0_sel = (i_sfr_addr == cmp_ctl_pkg::MODE0_ADDR);
  assign ctrl1_sel = (i_sfr_addr == cmp_ctl_pkg::CTRL1_ADDR);
  assign mode1_sel = (i_sfr_addr == cmp_ctl_pkg::MODE1_ADDR);
  assign ctrl0_wr  = i_sfr_wr & ctrl0_sel;
  assign mode0_wr  = i_sfr_wr & mode0_sel;
  assign ctrl1_wr  = i_sfr_wr & ctrl1_sel;
  assign mode1_wr  = i_sfr_wr & mode1_sel;
  assign mode_rd   = i_sfr_rd & (mode0_sel | mode1_sel);

  // Comparator 0, the only one wired to the reset logic
  cmp_channel u_cmp0 (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_cmp_raw   (i_cmp0_raw),
    .i_ctrl_wr   (ctrl0_wr),
    .i_mode_wr   (mode0_wr),
    .i_wdata     (i_sfr_wdata),
    .o_enable    (o_cmp0_enable),
    .o_state     (c0_state),
    .o_rise_flag (c0_rise),
    .o_fall_flag (c0_fall),
    .o_pos_hyst  (o_cmp0_pos_hyst),
    .o_neg_hyst  (o_cmp0_neg_hyst),
    .o_rise_ie   (c0_rie),
    .o_fall_ie   (c0_fie),
    .o_resp_mode (o_cmp0_resp_mode),
    .o_pin       (o_cmp0_pin),
    .o_rise_irq  (o_cmp0_rise_irq),
    .o_fall_irq  (o_cmp0_fall_irq)
  );

  // Comparator 1 reuses the same channel with its own registers
  cmp_channel u_cmp1 (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_cmp_raw   (i_cmp1_raw),
    .i_ctrl_wr   (ctrl1_wr),
    .i_mode_wr   (mode1_wr),
    .i_wdata     (i_sfr_wdata),
    .o_enable    (o_cmp1_enable),
    .o_state     (c1_state),
    .o_rise_flag (c1_rise),
    .o_fall_flag (c1_fall),
    .o_pos_hyst  (o_cmp1_pos_hyst),
    .o_neg_hyst  (o_cmp1_neg_hyst),
    .o_rise_ie   (c1_rie),
    .o_fall_ie   (c1_fie),
    .o_resp_mode (o_cmp1_resp_mode),
    .o_pin       (o_cmp1_pin),
    .o_rise_irq  (o_cmp1_rise_irq),
    .o_fall_irq  (o_cmp1_fall_irq)
  );

  // Control bytes: enable, live status, flags, hysteresis
  always_comb begin
    ctrl0_byte = cmp_ctl_pkg::READ_ZERO;
    ctrl0_byte[cmp_ctl_pkg::CTRL_EN_BIT]  = o_cmp0_enable;
    ctrl0_byte[cmp_ctl_pkg::CTRL_OUT_BIT] = c0_state;
    ctrl0_byte[cmp_ctl_pkg::CTRL_RIF_BIT] = c0_rise;
    ctrl0_byte[cmp_ctl_pkg::CTRL_FIF_BIT] = c0_fall;
    ctrl0_byte[cmp_ctl_pkg::CTRL_HYP_LSB +: cmp_ctl_pkg::HYST_W] = o_cmp0_pos_hyst;
    ctrl0_byte[cmp_ctl_pkg::CTRL_HYN_LSB +: cmp_ctl_pkg::HYST_W] = o_cmp0_neg_hyst;
    ctrl1_byte = cmp_ctl_pkg::READ_ZERO;
    ctrl1_byte[cmp_ctl_pkg::CTRL_EN_BIT]  = o_cmp1_enable;
    ctrl1_byte[cmp_ctl_pkg::CTRL_OUT_BIT] = c1_state;
    ctrl1_byte[cmp_ctl_pkg::CTRL_RIF_BIT] = c1_rise;
    ctrl1_byte[cmp_ctl_pkg::CTRL_FIF_BIT] = c1_fall;
    ctrl1_byte[cmp_ctl_pkg::CTRL_HYP_LSB +: cmp_ctl_pkg::HYST_W] = o_cmp1_pos_hyst;
    ctrl1_byte[cmp_ctl_pkg::CTRL_HYN_LSB +: cmp_ctl_pkg::HYST_W] = o_cmp1_neg_hyst;
  end

  // Mode bytes: unimplemented bits stay zero
  always_comb begin
    mode0_byte = cmp_ctl_pkg::READ_ZERO;
    mode0_byte[cmp_ctl_pkg::MODE_RIE_BIT] = c0_rie;
    mode0_byte[cmp_ctl_pkg::MODE_FIE_BIT] = c0_fie;
    mode0_byte[cmp_ctl_pkg::MODE_MD_LSB +: cmp_ctl_pkg::MD_W] = o_cmp0_resp_mode;
    mode1_byte = cmp_ctl_pkg::READ_ZERO;
    mode1_byte[cmp_ctl_pkg::MODE_RIE_BIT] = c1_rie;
    mode1_byte[cmp_ctl_pkg::MODE_FIE_BIT] = c1_fie;
    mode1_byte[cmp_ctl_pkg::MODE_MD_LSB +: cmp_ctl_pkg::MD_W] = o_cmp1_resp_mode;
  end

  // Read mux; an unmapped address answers zero
  always_comb begin
    if (ctrl0_sel) begin
      rdata_nxt = ctrl0_byte;
    end else if (mode0_sel) begin
      rdata_nxt = mode0_byte;
    end else if (ctrl1_sel) begin
      rdata_nxt = ctrl1_byte;
    end else if (mode1_sel) begin
      rdata_nxt = mode1_byte;
    end else begin
      rdata_nxt = cmp_ctl_pkg::READ_ZERO;
    end
  end

  // Registered read answer, one cycle after the read strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= cmp_ctl_pkg::READ_ZERO;
      o_sfr_hit   <= 1'b0;
    end else if (i_ce) begin
      if (i_sfr_rd) begin
        o_sfr_rdata <= rdata_nxt;
        o_sfr_hit   <= ctrl0_sel | mode0_sel | ctrl1_sel | mode1_sel;
      end else begin
        o_sfr_hit   <= 1'b0;
      end
    end
  end

  // Reset request while comparator 0 is on, chosen as source, and its output low
  assign rst_cond = o_cmp0_enable & i_cmp0_rst_src_en & ~c0_state;

  // Registered so a glitch on the live level cannot pulse the reset tree
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cmp0_reset_req <= 1'b0;
    end else if (i_ce) begin
      o_cmp0_reset_req <= rst_cond;
    end
  end

  // A rise of the live level while enabled must mark the rising flag
  property p_rise_sets;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && o_cmp0_enable && $past(o_cmp0_enable) && $rose(c0_state)) |=> c0_rise;
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising edge did not set rise flag");

  // A fall of the live level while enabled must mark the falling flag
  property p_fall_sets;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && o_cmp0_enable && $past(o_cmp0_enable) && $fell(c0_state)) |=> c0_fall;
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge did not set fall flag");

  // Without a control write a set flag stays set
  property p_flag_sticky;
    @(posedge i_ref_clk) disable iff (i_rst)
      (c1_rise && !ctrl1_wr) |=> c1_rise;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("rise flag dropped without a write");

  // Writing the enable bit takes effect at the next edge
  property p_enable_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && ctrl0_wr) |=> (o_cmp0_enable == $past(i_sfr_wdata[cmp_ctl_pkg::CTRL_EN_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow the write");

  // A disabled comparator drives its pin low and raises no rising interrupt
  property p_off_quiet;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !o_cmp1_enable) |=> (!o_cmp1_pin && (!o_cmp1_rise_irq || o_cmp1_enable));
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled comparator still active");

  // A flagged rise with its enable set requests an interrupt
  property p_rise_irq;
    @(posedge i_ref_clk) disable iff (i_rst)
      (c0_rise && c0_rie && o_cmp0_enable) |-> o_cmp0_rise_irq;
  endproperty
  a_rise_irq: assert property (p_rise_irq)
    else $error("rise interrupt missing");

  // No falling interrupt while its enable is clear
  property p_fall_irq_gate;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!c0_fie || !c0_fall) |-> !o_cmp0_fall_irq;
  endproperty
  a_fall_irq_gate: assert property (p_fall_irq_gate)
    else $error("fall interrupt raised while disabled");

  // The reset request follows its cause one cycle later
  property p_reset_req;
    @(posedge i_ref_clk) disable iff (i_rst)
      $past(i_ce) |-> (o_cmp0_reset_req == $past(rst_cond));
  endproperty
  a_reset_req: assert property (p_reset_req)
    else $error("reset request does not follow comparator 0");

  // Right after reset the second mode register holds response mode 2
  property p_mode1_reset;
    @(posedge i_ref_clk) disable iff (i_rst)
      $past(i_rst) |-> (mode1_byte == cmp_ctl_pkg::MODE_RST);
  endproperty
  a_mode1_reset: assert property (p_mode1_reset)
    else $error("mode register 1 reset value wrong");

  // Mode reads never show unimplemented bits
  property p_unused_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
      ($past(i_ce) && $past(mode_rd)) |-> ((o_sfr_rdata & ~cmp_ctl_pkg::MODE_MASK) == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused mode bits read nonzero");

  // A set falling flag of comparator 0 survives until software writes control 0
  property p_fall_sticky;
    @(posedge i_ref_clk) disable iff (i_rst)
      (c0_fall && !ctrl0_wr) |=> c0_fall;
  endproperty
  a_fall_sticky: assert property (p_fall_sticky)
    else $error("fall flag dropped without a write");

  // The routed pin repeats the gated live level one cycle later
  property p_pin_follows;
    @(posedge i_ref_clk) disable iff (i_rst)
      ($past(i_ce) && !$past(i_rst)) |-> (o_cmp0_pin == $past(c0_state));
  endproperty
  a_pin_follows: assert property (p_pin_follows)
    else $error("pin does not follow comparator 0");

  // Mode writes to comparator 1 land in its own interrupt enables
  property p_mode1_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && mode1_wr) |=>
        ((c1_rie == $past(i_sfr_wdata[cmp_ctl_pkg::MODE_RIE_BIT])) &&
         (c1_fie == $past(i_sfr_wdata[cmp_ctl_pkg::MODE_FIE_BIT])));
  endproperty
  a_mode1_write: assert property (p_mode1_write)
    else $error("mode register 1 write lost");

  // A frozen clock enable keeps enable and flags where they are
  property p_ce_freeze;
    @(posedge i_ref_clk) disable iff (i_rst)
      !i_ce |=> ($stable(o_cmp0_enable) && $stable(c0_rise) && $stable(c0_fall));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while the clock enable was low");

endmodule

/* File: tb/cmp_core_model.sv */
// Behavioural model of one analog comparator core as seen by the control logic
`timescale 1ns/10ps
module cmp_core_model (
  input  wire logic i_ref_clk,
  input  wire logic i_enable,
  input  wire logic i_level,
  output logic      o_raw
);
  logic junk_r = 1'b0;  // Meaningless level of an unpowered core

  // A shut-down core gives no valid answer, so let it chatter every cycle
  always @(negedge i_ref_clk) begin
    junk_r <= ~junk_r;
  end

  // Powered core follows the input difference; chatter shows up otherwise
  assign o_raw = i_enable ? i_level : junk_r;
endmodule

/* File: tb/test_analog_comparator_control.sv */
// Register-level testbench for the two-comparator control block
`timescale 1ns/10ps
module test_analog_comparator_control;
  logic        i_ref_clk, i_rst, i_ce, i_sfr_wr, i_sfr_rd, i_rst_src;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
  logic        o_sfr_hit, o_cmp0_reset_req;
  logic [1:0]  level_r;                                      // Analog input levels
  wire  [1:0]  raw_w, en_w, pin_w, rirq_w, firq_w;           // Per-channel views
  wire  [1:0][1:0] md_w;                                     // Response mode outputs
  wire  [1:0][1:0] hp_w, hn_w;                               // Hysteresis outputs
  int n_mismatch = 0;
  int compares   = 0;
  int cycles     = 0;

  analog_comparator_control dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_cmp0_raw(raw_w[0]),
    .i_cmp1_raw(raw_w[1]), .i_cmp0_rst_src_en(i_rst_src), .o_cmp0_enable(en_w[0]),
    .o_cmp0_resp_mode(md_w[0]), .o_cmp0_pos_hyst(hp_w[0]), .o_cmp0_neg_hyst(hn_w[0]),
    .o_cmp0_pin(pin_w[0]), .o_cmp0_rise_irq(rirq_w[0]), .o_cmp0_fall_irq(firq_w[0]),
    .o_cmp0_reset_req(o_cmp0_reset_req), .o_cmp1_enable(en_w[1]),
    .o_cmp1_resp_mode(md_w[1]), .o_cmp1_pos_hyst(hp_w[1]), .o_cmp1_neg_hyst(hn_w[1]),
    .o_cmp1_pin(pin_w[1]), .o_cmp1_rise_irq(rirq_w[1]), .o_cmp1_fall_irq(firq_w[1])
  );

  // One analog core model per channel, powered by the enable field
  cmp_core_model core0 (.i_ref_clk(i_ref_clk), .i_enable(en_w[0]), .i_level(level_r[0]),
                        .o_raw(raw_w[0]));
  cmp_core_model core1 (.i_ref_clk(i_ref_clk), .i_enable(en_w[1]), .i_level(level_r[1]),
                        .o_raw(raw_w[1]));

  // 40 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  // Compare one observed byte against its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Let a number of falling edges pass
  task automatic idle(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // Single-cycle write strobe, launched and dropped on falling edges
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr  = a;
    i_sfr_wdata = d;
    i_sfr_wr    = 1'b1;
    idle(1);
    i_sfr_wr    = 1'b0;
    idle(1);                                          // Strobe drops for one edge
  endtask

  // Single-cycle read; data and hit are registered one cycle after the strobe
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    i_sfr_addr = a;
    i_sfr_rd   = 1'b1;
    idle(1);
    i_sfr_rd   = 1'b0;
    check(o_sfr_rdata, exp);
    check({7'h0, o_sfr_hit}, {7'h0, hit});
    idle(1);                                          // Strobe drops for one edge
  endtask

  // Full edge, flag, interrupt and shutdown sequence on one channel
  task automatic run_channel(input int ch);
    logic [7:0] ca, ma;
    ca = (ch == 1) ? cmp_ctl_pkg::CTRL1_ADDR : cmp_ctl_pkg::CTRL0_ADDR;
    ma = (ch == 1) ? cmp_ctl_pkg::MODE1_ADDR : cmp_ctl_pkg::MODE0_ADDR;
    sfr_write(ca, 8'h80);
    check({6'h0, en_w}, (ch == 1) ? 8'h02 : 8'h01);
    idle(4);                                          // Stand-in for the power-up wait
    sfr_write(ca, 8'h80);                             // Clear stale flags
    sfr_read(ca, 8'h80, 1'b1);
    level_r[ch] = 1'b1;
    idle(5);
    sfr_read(ca, 8'he0, 1'b1);
    check({7'h0, pin_w[ch]}, 8'h01);
    check({6'h0, rirq_w[ch], firq_w[ch]}, 8'h00);
    level_r[ch] = 1'b0;
    idle(5);
    sfr_read(ca, 8'hb0, 1'b1);
    sfr_write(ma, 8'h10);
    check({6'h0, rirq_w[ch], firq_w[ch]}, 8'h01);
    sfr_write(ma, 8'h20);
    check({6'h0, rirq_w[ch], firq_w[ch]}, 8'h02);
    sfr_write(ma, 8'h30);
    check({6'h0, rirq_w[ch], firq_w[ch]}, 8'h03);
    if (ch == 0) begin
      i_rst_src = 1'b1;
      idle(2);
      check({7'h0, o_cmp0_reset_req}, 8'h01);
      level_r[0] = 1'b1;
      idle(5);
      check({7'h0, o_cmp0_reset_req}, 8'h00);
      level_r[0] = 1'b0;
      i_rst_src  = 1'b0;
      idle(5);
    end
    sfr_write(ca, 8'h30);                             // Shut down, keep both flags
    idle(1);
    check({5'h0, pin_w[ch], rirq_w[ch], firq_w[ch]}, 8'h00);
    level_r[ch] = 1'b1;
    idle(8);                                          // Core chatters while off
    sfr_read(ca, 8'h30, 1'b1);
    level_r[ch] = 1'b0;
    sfr_write(ca, 8'h00);
    sfr_write(ma, cmp_ctl_pkg::MODE_RST);
  endtask

  // Main sequence
  initial begin
    i_rst = 1'b1; i_ce = 1'b1; i_sfr_wr = 1'b0; i_sfr_rd = 1'b0; i_rst_src = 1'b0;
    i_sfr_addr = 8'h00; i_sfr_wdata = 8'h00; level_r = 2'b00;
    repeat (12) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    sfr_read(cmp_ctl_pkg::CTRL0_ADDR, cmp_ctl_pkg::CTRL_RST, 1'b1);
    sfr_read(cmp_ctl_pkg::MODE0_ADDR, 8'h02, 1'b1);
    sfr_read(cmp_ctl_pkg::CTRL1_ADDR, 8'h00, 1'b1);
    sfr_read(cmp_ctl_pkg::MODE1_ADDR, 8'h02, 1'b1);
    check({6'h0, md_w[1]}, 8'h02);
    i_ce = 1'b0;                                       // Frozen block must ignore writes
    sfr_write(cmp_ctl_pkg::MODE0_ADDR, 8'h33);
    i_ce = 1'b1;
    sfr_read(cmp_ctl_pkg::MODE0_ADDR, 8'h02, 1'b1);
    sfr_read(8'h8a, 8'h00, 1'b0);                      // Unmapped address
    sfr_write(cmp_ctl_pkg::MODE1_ADDR, 8'hff);
    sfr_read(cmp_ctl_pkg::MODE1_ADDR, 8'h33, 1'b1);
    for (int m = 0; m < 4; m++) begin
      sfr_write(cmp_ctl_pkg::MODE0_ADDR, 8'(m));
      check({6'h0, md_w[0]}, 8'(m));
      sfr_read(cmp_ctl_pkg::MODE0_ADDR, 8'(m), 1'b1);
    end
    for (int h = 0; h < 4; h++) begin
      sfr_write(cmp_ctl_pkg::CTRL1_ADDR, 8'((h << 2) | (3 - h)));
      check({4'h0, hp_w[1], hn_w[1]}, 8'((h << 2) | (3 - h)));
      sfr_write(cmp_ctl_pkg::CTRL0_ADDR, 8'((h << 2) | h));
      check({4'h0, hp_w[0], hn_w[0]}, 8'((h << 2) | h));
    end
    sfr_write(cmp_ctl_pkg::CTRL0_ADDR, 8'h00);
    sfr_write(cmp_ctl_pkg::CTRL1_ADDR, 8'h00);
    sfr_write(cmp_ctl_pkg::MODE1_ADDR, 8'h02);
    sfr_write(cmp_ctl_pkg::MODE0_ADDR, 8'h02);
    run_channel(0);
    run_channel(1);
    final_report();
  end
endmodule
